// >>> common/gpio_pkg.sv
`default_nettype none
package gpio_pkg;

	localparam int unsigned NUM_PORTS = 3;
	localparam int unsigned PORT_W    = 8;
	localparam int unsigned APB_AW    = 8;
	localparam int unsigned APB_DW    = 32;

	// Port numbering used on every per-port vector: 0 = A, 1 = B, 2 = C.
	localparam int unsigned PORT_A = 0;
	localparam int unsigned PORT_B = 1;
	localparam int unsigned PORT_C = 2;

	// Register indices; the byte address is four times the index.
	localparam logic [3:0] IDX_PORT_C_DATA      = 4'h0;
	localparam logic [3:0] IDX_PORT_C_DIRECTION = 4'h1;
	localparam logic [3:0] IDX_PORT_C_OPTION    = 4'h2;
	localparam logic [3:0] IDX_PORT_B_DATA      = 4'h4;
	localparam logic [3:0] IDX_PORT_B_DIRECTION = 4'h5;
	localparam logic [3:0] IDX_PORT_B_OPTION    = 4'h6;
	localparam logic [3:0] IDX_PORT_A_DATA      = 4'h8;
	localparam logic [3:0] IDX_PORT_A_DIRECTION = 4'h9;
	localparam logic [3:0] IDX_PORT_A_OPTION    = 4'hA;
	localparam logic [3:0] IDX_IRQ_STATUS       = 4'hC;
	localparam logic [3:0] IDX_IRQ_MASK         = 4'hD;

	// Address fields of the byte address.
	localparam int unsigned ADDR_IDX_LSB = 2;
	localparam int unsigned ADDR_IDX_MSB = 5;
	localparam int unsigned ADDR_TOP_LSB = 6;

	localparam logic [7:0]  PORT_RESET  = 8'h00;
	localparam logic [2:0]  GROUP_RESET = 3'h0;
	localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

	// Pins that exist on each port; port C has six.
	localparam logic [7:0] PINS_A = 8'hFF;
	localparam logic [7:0] PINS_B = 8'hFF;
	localparam logic [7:0] PINS_C = 8'h3F;

	typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_vec_t;

	// Software view of all three ports.
	typedef struct packed {
		port_vec_t data;
		port_vec_t direction;
		port_vec_t option;
	} port_regs_s;

	// Pad controls driven toward the pins.
	typedef struct packed {
		port_vec_t pin_out;
		port_vec_t pin_oe;
		port_vec_t pull_up;
	} pad_ctrl_s;

	// Interrupt bookkeeping: request, status and mask bits per port group, and one irq bit.
	typedef struct packed {
		logic [NUM_PORTS-1:0] request;
		logic [NUM_PORTS-1:0] status;
		logic [NUM_PORTS-1:0] mask;
		logic                 irq;
	} irq_regs_s;

	// Registered APB answer.
	typedef struct packed {
		logic              ready;
		logic              slverr;
		logic [APB_DW-1:0] rdata;
	} apb_resp_s;

endpackage : gpio_pkg
`default_nettype wire

// >>> design/three_port_gpio_block.sv
// Functional notes
// - Direction bit 0 input, 1 output.
// - Data writes always update the output latch.
// - Data read: latch if output, pin if input.
// - Input option 0 floating, 1 interrupt input.
// - Ports B, C output: open drain or push-pull.
// - Port A output is true open drain.
// - Pull-up and high side only when needed.
// - All port registers reset to zero.
// - Unimplemented option bits: direction alone decides.
// - Register bit n controls pin n.
// - Enabled interrupt pins ORed per group.
// - Pins set to output by direction never raise interrupt requests.
// - Alternate peripheral output overrides data and direction.
`default_nettype none
module three_port_gpio_block #(
	parameter logic [7:0] OPTION_IMPL_A = 8'hFF,
	parameter logic [7:0] OPTION_IMPL_B = 8'hFF,
	parameter logic [7:0] OPTION_IMPL_C = 8'hFF
) (
	input  wire logic                      CLK_SYS_I,
	input  wire logic                      NRST_I,
	input  wire logic                      PSEL_I,
	input  wire logic                      PENABLE_I,
	input  wire logic                      PWRITE_I,
	input  wire logic [gpio_pkg::APB_AW-1:0] PADDR_I,
	input  wire logic [gpio_pkg::APB_DW-1:0] PWDATA_I,
	input  wire logic [3:0]                PSTRB_I,
	output logic                           PREADY_O,
	output logic                           PSLVERR_O,
	output logic [gpio_pkg::APB_DW-1:0]    PRDATA_O,
	input  wire gpio_pkg::port_vec_t       PIN_I,
	output gpio_pkg::port_vec_t            PIN_O,
	output gpio_pkg::port_vec_t            PIN_OE_O,
	output gpio_pkg::port_vec_t            PULL_UP_O,
	input  wire gpio_pkg::port_vec_t       ALT_EN_I,
	input  wire gpio_pkg::port_vec_t       ALT_OUT_I,
	output logic [gpio_pkg::NUM_PORTS-1:0] EXT_IRQ_O,
	output logic                           IRQ_O
);

	typedef struct packed {
		gpio_pkg::port_regs_s regs;
		gpio_pkg::port_vec_t  sync_first;
		gpio_pkg::port_vec_t  sync_second;
		gpio_pkg::pad_ctrl_s  pad;
		gpio_pkg::irq_regs_s  irq;
		gpio_pkg::apb_resp_s  resp;
	} state_s;

	state_s cur;
	state_s next_cur;

	gpio_pkg::port_vec_t pins_present;
	gpio_pkg::port_vec_t option_impl;

	assign pins_present[gpio_pkg::PORT_A] = gpio_pkg::PINS_A;
	assign pins_present[gpio_pkg::PORT_B] = gpio_pkg::PINS_B;
	assign pins_present[gpio_pkg::PORT_C] = gpio_pkg::PINS_C;
	assign option_impl[gpio_pkg::PORT_A]  = OPTION_IMPL_A;
	assign option_impl[gpio_pkg::PORT_B]  = OPTION_IMPL_B;
	assign option_impl[gpio_pkg::PORT_C]  = OPTION_IMPL_C;

	// Maps a register index to its port and kind; kind 0 data, 1 direction, 2 option.
	function automatic logic port_decode(input logic [3:0] idx, output int unsigned port,
			output int unsigned kind);
		logic hit;
		hit  = 1'b1;
		port = gpio_pkg::PORT_A;
		kind = 0;
		case (idx)
			gpio_pkg::IDX_PORT_A_DATA: begin
				port = gpio_pkg::PORT_A;
				kind = 0;
			end
			gpio_pkg::IDX_PORT_A_DIRECTION: begin
				port = gpio_pkg::PORT_A;
				kind = 1;
			end
			gpio_pkg::IDX_PORT_A_OPTION: begin
				port = gpio_pkg::PORT_A;
				kind = 2;
			end
			gpio_pkg::IDX_PORT_B_DATA: begin
				port = gpio_pkg::PORT_B;
				kind = 0;
			end
			gpio_pkg::IDX_PORT_B_DIRECTION: begin
				port = gpio_pkg::PORT_B;
				kind = 1;
			end
			gpio_pkg::IDX_PORT_B_OPTION: begin
				port = gpio_pkg::PORT_B;
				kind = 2;
			end
			gpio_pkg::IDX_PORT_C_DATA: begin
				port = gpio_pkg::PORT_C;
				kind = 0;
			end
			gpio_pkg::IDX_PORT_C_DIRECTION: begin
				port = gpio_pkg::PORT_C;
				kind = 1;
			end
			gpio_pkg::IDX_PORT_C_OPTION: begin
				port = gpio_pkg::PORT_C;
				kind = 2;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return hit;
	endfunction

	logic [3:0]  reg_idx;
	logic        addr_ok;
	logic        port_hit;
	int unsigned hit_port;
	int unsigned hit_kind;
	logic        access;

	assign reg_idx = PADDR_I[gpio_pkg::ADDR_IDX_MSB:gpio_pkg::ADDR_IDX_LSB];
	assign addr_ok = (PADDR_I[gpio_pkg::ADDR_IDX_LSB-1:0] == 2'b00)
		&& (PADDR_I[gpio_pkg::APB_AW-1:gpio_pkg::ADDR_TOP_LSB] == '0);
	assign access  = PSEL_I && PENABLE_I;

	always_comb begin
		port_hit = port_decode(reg_idx, hit_port, hit_kind);
	end

	always_comb begin
		gpio_pkg::port_vec_t  opt_eff;
		gpio_pkg::port_vec_t  read_view;
		gpio_pkg::port_vec_t  irq_pin;
		logic [7:0]           byte_rd;
		logic [gpio_pkg::NUM_PORTS-1:0] group_req;
		logic                 mapped;
		opt_eff   = '0;
		read_view = '0;
		irq_pin   = '0;
		byte_rd   = 8'h00;
		group_req = '0;
		mapped    = 1'b0;
		next_cur  = cur;

		// The first stage feeds only the second stage.
		next_cur.sync_first  = PIN_I;
		next_cur.sync_second = cur.sync_first;

		for (int p = 0; p < gpio_pkg::NUM_PORTS; p++) begin
			// Missing option bits read as zero, so direction alone selects the mode.
			opt_eff[p] = cur.regs.option[p] & option_impl[p];
			// Per-bit mux keeps pin n tied to bit n of every register.
			read_view[p] = (cur.regs.direction[p] & cur.regs.data[p])
				| (~cur.regs.direction[p] & cur.sync_second[p]);
			// Interrupts follow the reset polarity: an enabled input held low requests.
			irq_pin[p] = ~cur.regs.direction[p] & opt_eff[p] & ~cur.sync_second[p]
				& pins_present[p];
			group_req[p] = |irq_pin[p];

			for (int n = 0; n < gpio_pkg::PORT_W; n++) begin
				next_cur.pad.pin_out[p][n] = 1'b0;
				next_cur.pad.pin_oe[p][n]  = 1'b0;
				next_cur.pad.pull_up[p][n] = 1'b0;
				if (!pins_present[p][n]) begin
					next_cur.pad.pin_out[p][n] = 1'b0;
				end else if (ALT_EN_I[p][n]) begin
					next_cur.pad.pin_out[p][n] = ALT_OUT_I[p][n];
					next_cur.pad.pin_oe[p][n]  = 1'b1;
				end else if (cur.regs.direction[p][n]) begin
					if (p != gpio_pkg::PORT_A && opt_eff[p][n]) begin
						next_cur.pad.pin_out[p][n] = cur.regs.data[p][n];
						next_cur.pad.pin_oe[p][n]  = 1'b1;
					end else begin
						// Only the low side drives; port A's reserved setting falls here too.
						next_cur.pad.pin_oe[p][n] = ~cur.regs.data[p][n];
					end
				end else begin
					next_cur.pad.pull_up[p][n] = (p != gpio_pkg::PORT_A)
						&& opt_eff[p][n];
				end
			end
		end

		next_cur.irq.request = group_req;
		// A new request in the clearing cycle survives because the set is applied last.
		next_cur.irq.status = cur.irq.status;
		if (access && cur.resp.ready && PWRITE_I && addr_ok && PSTRB_I[0]
				&& reg_idx == gpio_pkg::IDX_IRQ_STATUS) begin
			next_cur.irq.status = cur.irq.status
				& ~PWDATA_I[gpio_pkg::NUM_PORTS-1:0];
		end
		next_cur.irq.status = next_cur.irq.status | (group_req & ~cur.irq.request);
		next_cur.irq.irq = |(next_cur.irq.status & cur.irq.mask);

		// One wait state: ready rises on the second access cycle, where the write lands.
		if (access && cur.resp.ready && PWRITE_I && addr_ok && PSTRB_I[0]) begin
			if (port_hit) begin
				case (hit_kind)
					0: begin
						next_cur.regs.data[hit_port] = PWDATA_I[7:0]
							& pins_present[hit_port];
					end
					1: begin
						next_cur.regs.direction[hit_port] = PWDATA_I[7:0]
							& pins_present[hit_port];
					end
					default: begin
						next_cur.regs.option[hit_port] = PWDATA_I[7:0]
							& pins_present[hit_port] & option_impl[hit_port];
					end
				endcase
			end else if (reg_idx == gpio_pkg::IDX_IRQ_MASK) begin
				next_cur.irq.mask = PWDATA_I[gpio_pkg::NUM_PORTS-1:0];
			end
		end

		if (port_hit) begin
			case (hit_kind)
				0: begin
					byte_rd = read_view[hit_port] & pins_present[hit_port];
				end
				1: begin
					byte_rd = cur.regs.direction[hit_port];
				end
				default: begin
					byte_rd = opt_eff[hit_port];
				end
			endcase
		end else if (reg_idx == gpio_pkg::IDX_IRQ_STATUS) begin
			byte_rd = {5'h00, cur.irq.status};
		end else if (reg_idx == gpio_pkg::IDX_IRQ_MASK) begin
			byte_rd = {5'h00, cur.irq.mask};
		end
		mapped = addr_ok && (port_hit || reg_idx == gpio_pkg::IDX_IRQ_STATUS
			|| reg_idx == gpio_pkg::IDX_IRQ_MASK);

		next_cur.resp.ready  = access && !cur.resp.ready;
		next_cur.resp.slverr = access && !cur.resp.ready && !mapped;
		next_cur.resp.rdata  = gpio_pkg::RDATA_ZERO;
		if (access && !cur.resp.ready && !PWRITE_I && mapped) begin
			next_cur.resp.rdata = {24'h000000, byte_rd};
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (!NRST_I) begin
			cur.regs.data        <= {gpio_pkg::NUM_PORTS{gpio_pkg::PORT_RESET}};
			cur.regs.direction   <= {gpio_pkg::NUM_PORTS{gpio_pkg::PORT_RESET}};
			cur.regs.option      <= {gpio_pkg::NUM_PORTS{gpio_pkg::PORT_RESET}};
			cur.sync_first       <= '0;
			cur.sync_second      <= '0;
			cur.pad              <= '0;
			cur.irq.request      <= gpio_pkg::GROUP_RESET;
			cur.irq.status       <= gpio_pkg::GROUP_RESET;
			cur.irq.mask         <= gpio_pkg::GROUP_RESET;
			cur.irq.irq          <= 1'b0;
			cur.resp.ready       <= 1'b0;
			cur.resp.slverr      <= 1'b0;
			cur.resp.rdata       <= gpio_pkg::RDATA_ZERO;
		end else begin
			cur <= next_cur;
		end
	end

	assign PREADY_O  = cur.resp.ready;
	assign PSLVERR_O = cur.resp.slverr;
	assign PRDATA_O  = cur.resp.rdata;
	assign PIN_O     = cur.pad.pin_out;
	assign PIN_OE_O  = cur.pad.pin_oe;
	assign PULL_UP_O = cur.pad.pull_up;
	assign EXT_IRQ_O = cur.irq.request;
	assign IRQ_O     = cur.irq.irq;

endmodule // three_port_gpio_block
`default_nettype wire

// >>> sim/gpio_block_properties.sv
`default_nettype none
module gpio_block_properties (
	input wire logic                       CLK_SYS_I,
	input wire logic                       NRST_I,
	input wire logic                       PSEL_I,
	input wire logic                       PENABLE_I,
	input wire logic                       PREADY_O,
	input wire logic                       PSLVERR_O,
	input wire logic [gpio_pkg::APB_DW-1:0] PRDATA_O,
	input wire gpio_pkg::port_vec_t        PIN_O,
	input wire gpio_pkg::port_vec_t        PIN_OE_O,
	input wire gpio_pkg::port_vec_t        PULL_UP_O,
	input wire gpio_pkg::port_vec_t        ALT_EN_I,
	input wire gpio_pkg::port_vec_t        ALT_OUT_I,
	input wire logic [gpio_pkg::NUM_PORTS-1:0] EXT_IRQ_O,
	input wire logic                       IRQ_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!NRST_I);
	sequence s_access;
		PSEL_I && PENABLE_I && !PREADY_O;
	endsequence
	sequence s_answer;
		PREADY_O ##1 !PREADY_O;
	endsequence
	chk_ready_wait: assert property (s_access |=> s_answer)
		else $error("ready not one cycle after access");
	chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("slverr without ready");
	chk_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("rdata not zero outside ready");
	chk_reset_quiet: assert property ($rose(NRST_I) |-> !PREADY_O && !IRQ_O
		&& PIN_OE_O == 24'h0 && PULL_UP_O == 24'h0 && EXT_IRQ_O == 3'h0)
		else $error("outputs active after reset");
	chk_alt_override: assert property (ALT_EN_I != 24'h0 |=>
		((~PIN_OE_O | (PIN_O ^ $past(ALT_OUT_I))) & $past(ALT_EN_I)) == 24'h0)
		else $error("alternate output not applied");
	chk_porta_drain: assert property (((PIN_O[0] & PIN_OE_O[0]) & ~$past(ALT_EN_I[0])) == 8'h0)
		else $error("port A drives high");
	chk_pullup_input: assert property ((PIN_OE_O & PULL_UP_O) == 24'h0 && PULL_UP_O[0] == 8'h0)
		else $error("pull-up in wrong mode");
	chk_portc_absent: assert property ((PIN_OE_O[2][7:6] | PIN_O[2][7:6] | PULL_UP_O[2][7:6]) == 2'b00)
		else $error("missing port C pin active");
endmodule // gpio_block_properties
`default_nettype wire

// >>> sim/gpio_board_model.sv
`default_nettype none
module gpio_board_model (
	input  wire logic                clk_i,
	input  wire gpio_pkg::port_vec_t drv_i,
	input  wire gpio_pkg::port_vec_t oe_i,
	input  wire gpio_pkg::port_vec_t pu_i,
	input  wire gpio_pkg::port_vec_t ext_en_i,
	input  wire gpio_pkg::port_vec_t ext_val_i,
	output var gpio_pkg::port_vec_t  pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog = 1'b0;
	// A floating pin keeps changing, so no stale level can pass for a real one.
	always @(posedge clk_i) tog <= ~tog;
	assign pin_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i)
		| (~oe_i & ~ext_en_i & (pu_i | {24{tog}}));
endmodule // gpio_board_model
`default_nettype wire

// >>> sim/test_three_port_gpio_block.sv
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_three_port_gpio_block;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk = 1'b0;
	logic                nrst = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [7:0]          paddr = 8'h00;
	logic [31:0]         pwdata = 32'h0;
	logic                pready, pslverr, irq, rerr;
	logic [31:0]         prdata, rdata;
	logic [2:0]          ext_irq;
	gpio_pkg::port_vec_t pin_i, pin_o, pin_oe, pull_up;
	// The board holds every pin low from the start, so data reads after reset are known zeros.
	gpio_pkg::port_vec_t alt_en = 24'h0, alt_out = 24'h0, ext_en = 24'hFFFFFF, ext_val = 24'h0;
	int                  miscompares = 0, checked = 0, cycles = 0;

	three_port_gpio_block uut (
		.CLK_SYS_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata), .PIN_I(pin_i),
		.PIN_O(pin_o), .PIN_OE_O(pin_oe), .PULL_UP_O(pull_up), .ALT_EN_I(alt_en),
		.ALT_OUT_I(alt_out), .EXT_IRQ_O(ext_irq), .IRQ_O(irq));
	gpio_board_model board (.clk_i(clk), .drv_i(pin_o), .oe_i(pin_oe), .pu_i(pull_up),
		.ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin_i));

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One idle edge after each transfer keeps two requests from sharing a time step.
	task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		apb(1'b1, i, {24'h0, d});
	endtask
	task automatic rd(input logic [3:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h0);
		`CHK("prdata", e, rdata)
	endtask

	task automatic reset_check();
		for (int i = 0; i < 11; i++) begin
			if (i % 4 != 3) rd(i[3:0], 32'h0);
		end
		apb(1'b0, 4'h3, 32'h0);
		`CHK("slverr", 1'b1, rerr)
		`CHK("oe", 24'h0, pin_oe)
	endtask
	task automatic port_b_modes();
		ext_en <= 24'hFFFFFF;
		ext_val <= 24'h3C5A96;
		wr(gpio_pkg::IDX_PORT_B_DATA, 8'hA5);
		repeat (4) @(posedge clk);
		rd(gpio_pkg::IDX_PORT_B_DATA, 32'h5A);
		wr(gpio_pkg::IDX_PORT_B_DIRECTION, 8'hFF);
		wr(gpio_pkg::IDX_PORT_B_OPTION, 8'hFF);
		rd(gpio_pkg::IDX_PORT_B_DATA, 32'hA5);
		`CHK("oe_b", 8'hFF, pin_oe[1])
		`CHK("out_b", 8'hA5, pin_o[1])
		wr(gpio_pkg::IDX_PORT_B_OPTION, 8'h00);
		repeat (2) @(posedge clk);
		`CHK("oe_b", 8'h5A, pin_oe[1])
		`CHK("out_b", 8'h00, pin_o[1])
	endtask
	task automatic port_a_mixed();
		wr(gpio_pkg::IDX_PORT_A_DATA, 8'h0F);
		wr(gpio_pkg::IDX_PORT_A_DIRECTION, 8'hF0);
		rd(gpio_pkg::IDX_PORT_A_DATA, 32'h06);
		`CHK("oe_a", 8'hF0, pin_oe[0])
		`CHK("out_a", 8'h00, pin_o[0])
		alt_en[0][0] <= 1'b1;
		alt_out[0][0] <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("alt_a", 2'b11, {pin_oe[0][0], pin_o[0][0]})
		alt_en[0][0] <= 1'b0;
	endtask
	task automatic port_c_irq();
		wr(gpio_pkg::IDX_PORT_C_DATA, 8'hFF);
		rd(gpio_pkg::IDX_PORT_C_DATA, 32'h3C);
		ext_val[2] <= 8'hFF;
		wr(gpio_pkg::IDX_PORT_C_OPTION, 8'hFF);
		rd(gpio_pkg::IDX_PORT_C_OPTION, 32'h3F);
		`CHK("pull_c", 8'h3F, pull_up[2])
		ext_val[2][1] <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK("ext_irq", 3'h4, ext_irq)
		`CHK("irq", 1'b0, irq)
		rd(gpio_pkg::IDX_IRQ_STATUS, 32'h4);
		wr(gpio_pkg::IDX_IRQ_MASK, 8'h04);
		repeat (2) @(posedge clk);
		`CHK("irq", 1'b1, irq)
		wr(gpio_pkg::IDX_IRQ_STATUS, 8'h04);
		repeat (2) @(posedge clk);
		`CHK("irq", 1'b0, irq)
		wr(gpio_pkg::IDX_PORT_C_DIRECTION, 8'h02);
		repeat (3) @(posedge clk);
		`CHK("ext_irq", 3'h0, ext_irq)
	endtask

	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		reset_check();
		port_b_modes();
		port_a_mixed();
		port_c_irq();
		stop_test();
	end
endmodule // test_three_port_gpio_block
bind three_port_gpio_block gpio_block_properties u_props (.CLK_SYS_I, .NRST_I, .PSEL_I,
	.PENABLE_I, .PREADY_O, .PSLVERR_O, .PRDATA_O, .PIN_O, .PIN_OE_O, .PULL_UP_O,
	.ALT_EN_I, .ALT_OUT_I, .EXT_IRQ_O, .IRQ_O);
`default_nettype wire
